// [design/rx_framer_decoder_bist.sv]
// Receive framer, 10B/8B decoder, parity and self-test checker per channel
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Framer disabled: boundaries never move
// - Framer enabled: chosen type on all channels
// - Low-latency framer stretches clock from first comma
// - At most two bits stretch per cycle
// - Character-rate clock: framed within nine cycles
// - Half-rate clock: framed within fourteen cycles
// - Mid mode: two commas, same boundary, 50 bits
// - High mode: four consecutive commas, same boundary
// - Decode; data status 000b, special 001b
// - Decoder low: raw characters, own clocks
// - Special codes: primary or alternate mapping
// - Odd parity beside each output character
// - Self-test latch transparent high, holds low
// - Reset sets self-test latch all high
// - Pattern register becomes 511-character LFSR checker
// - First enable presets LFSR to D0.0
// - Common clocking: word sync precedes each pass
// - Report mismatches, not loop violations
// - Loop end shows 010b or 100b once
// - Self-test status same in every decoder mode
// - Sixteen more bad than good: restart hunt
// - Comma and K28.5 patterns per selection
module rx_framer_decoder_bist #(
   parameter int NUM_CH = 4
) (
   input  wire logic                               clk_i,
   input  wire logic                               rst_i,
   input  wire logic [rx_fdb_pkg::ADDR_W-1:0]      wb_adr_i,
   input  wire logic [31:0]                        wb_dat_i,
   output logic      [31:0]                        wb_dat_o,
   input  wire logic                               wb_we_i,
   input  wire logic [3:0]                         wb_sel_i,
   input  wire logic                               wb_cyc_i,
   input  wire logic                               wb_stb_i,
   output logic                                    wb_ack_o,
   input  wire logic [NUM_CH-1:0]                  rx_bit_i,
   output rx_fdb_pkg::rx_char_t [NUM_CH-1:0]       rx_out_o,
   output logic      [NUM_CH-1:0]                  rx_valid_o,
   output logic      [NUM_CH-1:0]                  rx_clk_o
);
   import rx_fdb_pkg::*;

   logic [31:0]           ctrl_q;
   ctrl_t                 ctrl;
   logic [7:0]            latch_held;
   logic [7:0]            latch_eff;
   logic [NUM_CH*8-1:0]   stat_img;
   logic                  bus_req;

   assign ctrl    = ctrl_t'(ctrl_q & CTRL_MASK);
   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   // Answer one cycle after the request, drop it the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'h0;
      end else begin
         wb_ack_o <= bus_req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= CTRL_RST;
      end else if (bus_req && wb_we_i && wb_adr_i == CTRL_OFS) begin
         for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) ctrl_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
         end
      end
   end

   // Unmapped reads return zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (bus_req) begin
         case (wb_adr_i)
            CTRL_OFS: wb_dat_o <= 32'(ctrl);
            STAT_OFS: wb_dat_o <= 32'(stat_img);
            default:  wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         latch_held <= 8'hFF;
      end else if (ctrl.selftest_latch_enable) begin
         latch_held <= ctrl.channel_enable_bus;
      end
   end

   assign latch_eff = ctrl.selftest_latch_enable ?
                      ctrl.channel_enable_bus : latch_held;

   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic [1:0]  sync;
      logic        bit_now;
      logic [17:0] hist;
      logic [18:0] win;
      logic [3:0]  bcnt;
      logic [3:0]  hold;
      logic [3:0]  pend;
      logic [3:0]  off;
      logic [3:0]  cand_p;
      logic        cand_v;
      logic [5:0]  age;
      logic [2:0]  run;
      logic [2:0]  next_run;
      logic        det;
      logic        same_bnd;
      logic        stb;
      logic [9:0]  chr;
      logic [5:0]  d6;
      logic [4:0]  d4;
      logic        is_k28;
      logic        is_spec;
      logic        is_bad;
      logic [7:0]  byte_pri;
      logic [7:0]  byte_alt;
      logic [7:0]  byte_out;
      bist_state_t bstate;
      logic [8:0]  lfsr;
      logic [4:0]  bal;
      logic        loop_err;
      logic        bist_en;
      logic        match;
      logic        loop_end;
      logic [2:0]  bist_st;
      logic [9:0]  next_data;
      logic [2:0]  next_status;

      // Pin from the recovered bit stream, two flops before use
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            sync <= 2'h0;
         end else begin
            sync <= {sync[0], rx_bit_i[ch]};
         end
      end
      assign bit_now = sync[1];

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            hist <= 18'h0_0000;
         end else begin
            hist <= {hist[16:0], bit_now};
         end
      end
      assign win = {hist, bit_now};

      always_comb begin
         case (ctrl.framing_char_select)
            LVL_MID:  det = win[9:2] == COMMA_POS ||
                            win[9:2] == ~COMMA_POS;
            LVL_HIGH: det = win[9:0] == K285_NEG ||
                            win[9:0] == ~K285_NEG;
            default:  det = 1'h0;
         endcase
      end

      assign same_bnd = cand_v && cand_p == bcnt;
      assign next_run = (same_bnd && age == AGE_NEXT_CHAR) ?
                        ((run == ALT_MIN_COMMAS) ? run : run + 3'h1) :
                        3'h1;
      assign stb = hold == 4'h0 && bcnt == CHAR_LAST;

      // Character counter; a stretch holds it so the clock lengthens
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            bcnt <= 4'h0;
            hold <= 4'h0;
         end else if (hold != 4'h0) begin
            hold <= hold - 4'h1;
         end else if (bcnt == CHAR_LAST) begin
            bcnt <= 4'h0;
            hold <= (pend > LL_MAX_STRETCH) ? LL_MAX_STRETCH : pend;
         end else begin
            bcnt <= bcnt + 4'h1;
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            age <= AGE_MAX;
         end else if (ctrl.framer_enable && det) begin
            age <= 6'h00;
         end else if (age != AGE_MAX) begin
            age <= age + 6'h01;
         end
      end

      // Only the stretch countdown runs while the framer is off, so boundaries stay
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            pend   <= 4'h0;
            off    <= 4'h0;
            cand_p <= 4'h0;
            cand_v <= 1'h0;
            run    <= 3'h0;
         end else begin
            if (hold == 4'h0 && bcnt == CHAR_LAST) begin
               pend <= (pend > LL_MAX_STRETCH) ?
                       pend - LL_MAX_STRETCH : 4'h0;
            end
            if (ctrl.framer_enable && det) begin
               cand_p <= bcnt;
               cand_v <= 1'h1;
               run    <= next_run;
               case (ctrl.framer_mode_select)
                  LVL_LOW: begin
                     // Stretch until the clock edge meets the comma
                     if (pend == 4'h0 && hold == 4'h0) begin
                        pend <= (bcnt == CHAR_LAST) ?
                                4'h0 : bcnt + 4'h1;
                        off  <= 4'h0;
                     end
                  end
                  LVL_MID: begin
                     if (same_bnd && age < MB_SPAN_BITS) begin
                        off <= CHAR_LAST - bcnt;
                     end
                  end
                  LVL_HIGH: begin
                     if (next_run == ALT_MIN_COMMAS) begin
                        off <= CHAR_LAST - bcnt;
                     end
                  end
                  default: begin
                     off <= off;
                  end
               endcase
            end
         end
      end

      // Decoder works on the framed character every strobe
      assign chr      = win[off +: 10];
      assign d6       = dec6(chr[9:4]);
      assign d4       = dec4(chr[3:0]);
      assign is_k28   = chr[9:4] == K28_6B || chr[9:4] == ~K28_6B;
      assign byte_pri = {d4[2:0], d6[4:0]};
      assign is_spec  = is_k28 || (d4[3] && legal_special(byte_pri));
      assign is_bad   = !d6[5] || !d4[4];

      always_comb begin
         if (is_k28) begin
            byte_alt = {5'h00, d4[2:0]};
         end else if (d6[4:0] == X_K23) begin
            byte_alt = ALT_K23;
         end else if (d6[4:0] == X_K27) begin
            byte_alt = ALT_K27;
         end else if (d6[4:0] == X_K29) begin
            byte_alt = ALT_K29;
         end else begin
            byte_alt = ALT_K30;
         end
      end

      assign byte_out = (is_spec &&
                         ctrl.decoder_mode_select == LVL_HIGH) ?
                        byte_alt : byte_pri;

      // Expected symbol: top LFSR bit marks a special or violation slot
      always_comb begin
         if (!lfsr[8]) begin
            match = !is_bad && !is_spec && byte_pri == lfsr[7:0];
         end else if (legal_special(lfsr[7:0])) begin
            match = !is_bad && is_spec && byte_pri == lfsr[7:0];
         end else begin
            match = is_bad;
         end
      end

      assign bist_en  = ~latch_eff[2*ch];
      assign loop_end = lfsr_next(lfsr) == LFSR_START;

      always_comb begin
         case (bstate)
            BS_CHECK: begin
               if (loop_end) begin
                  bist_st = (loop_err || !match) ?
                            ST_LOOP_ERR : ST_LOOP_OK;
               end else if (!match) begin
                  bist_st = ST_MISMATCH;
               end else begin
                  bist_st = is_spec ? ST_SPECIAL : ST_DATA;
               end
            end
            default: bist_st = ST_BIST_WAIT;
         endcase
      end

      always_ff @(posedge clk_i) begin
         if (rst_i || !bist_en) begin
            bstate   <= BS_OFF;
            lfsr     <= LFSR_START;
            bal      <= 5'h00;
            loop_err <= 1'h0;
         end else if (stb) begin
            case (bstate)
               BS_OFF: begin
                  bstate <= BS_HUNT;
                  lfsr   <= LFSR_START;
               end
               BS_HUNT: begin
                  // Word sync and stray characters pass while hunting
                  if (match && lfsr == LFSR_START) begin
                     bstate   <= BS_CHECK;
                     lfsr     <= lfsr_next(LFSR_START);
                     bal      <= 5'h00;
                     loop_err <= 1'h0;
                  end
               end
               BS_CHECK: begin
                  if (!match && bal == BIST_ABORT_BAL - 5'h01) begin
                     bstate <= BS_HUNT;
                     lfsr   <= LFSR_START;
                     bal    <= 5'h00;
                  end else begin
                     lfsr     <= lfsr_next(lfsr);
                     bal      <= match ? ((bal == 5'h00) ? bal : bal - 5'h01)
                                       : bal + 5'h01;
                     loop_err <= loop_end ? 1'h0 : (loop_err | !match);
                  end
               end
               default: bstate <= BS_OFF;
            endcase
         end
      end

      always_comb begin
         if (ctrl.decoder_mode_select == LVL_LOW) begin
            next_data   = chr;
            next_status = ST_DATA;
         end else begin
            next_data   = {2'h0, byte_out};
            next_status = is_bad ? ST_INVALID :
                          (is_spec ? ST_SPECIAL : ST_DATA);
         end
         if (bstate != BS_OFF) begin
            next_status = bist_st;
         end
      end

      // Each channel gets its own strobe and clock, never bonded
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            rx_out_o[ch]   <= '0;
            rx_valid_o[ch] <= 1'h0;
            rx_clk_o[ch]   <= 1'h0;
         end else begin
            rx_valid_o[ch] <= stb;
            if (stb) begin
               rx_out_o[ch].data   <= next_data;
               rx_out_o[ch].status <= next_status;
               rx_out_o[ch].parity <= ~^next_data;
               rx_clk_o[ch] <= ctrl.rx_clock_rate_select ?
                               ~rx_clk_o[ch] : 1'h1;
            end else if (!ctrl.rx_clock_rate_select) begin
               rx_clk_o[ch] <= 1'h0;
            end
         end
      end

      assign stat_img[8*ch +: 8] = {2'h0, bstate, rx_out_o[ch].status};
   end

endmodule
`default_nettype wire

// [shared/rx_fdb_pkg.sv]
// Constants, types and code tables for the receive framer, decoder and self-test
package rx_fdb_pkg;

   // Three-level strap style selections
   typedef enum logic [1:0] {
      LVL_LOW  = 2'h0,
      LVL_MID  = 2'h1,
      LVL_HIGH = 2'h2
   } tri_lvl_t;

   // Control register image, bit 0 at the bottom
   typedef struct packed {
      logic [7:0] rsvd_hi;
      logic [7:0] channel_enable_bus;
      logic [4:0] rsvd_lo;
      logic       selftest_latch_enable;
      tri_lvl_t   rx_clock_select;
      logic       rx_clock_rate_select;
      tri_lvl_t   decoder_mode_select;
      tri_lvl_t   framing_char_select;
      tri_lvl_t   framer_mode_select;
      logic       framer_enable;
   } ctrl_t;

   // One output register entry of a channel
   typedef struct packed {
      logic [9:0] data;
      logic [2:0] status;
      logic       parity;
   } rx_char_t;

   // Self-test checker states
   typedef enum logic [2:0] {
      BS_OFF   = 3'h1,
      BS_HUNT  = 3'h2,
      BS_CHECK = 3'h4
   } bist_state_t;

   // Register map (byte addresses)
   localparam int          ADDR_W    = 4;
   localparam logic [3:0]  CTRL_OFS  = 4'h0;
   localparam logic [3:0]  STAT_OFS  = 4'h4;
   localparam logic [31:0] CTRL_RST  = 32'h00FF_052A;
   localparam logic [31:0] CTRL_MASK = 32'h00FF_07FF;

   // Status codes on the output register
   localparam logic [2:0] ST_DATA      = 3'h0;
   localparam logic [2:0] ST_SPECIAL   = 3'h1;
   localparam logic [2:0] ST_LOOP_OK   = 3'h2;
   localparam logic [2:0] ST_BIST_WAIT = 3'h3;
   localparam logic [2:0] ST_LOOP_ERR  = 3'h4;
   localparam logic [2:0] ST_MISMATCH  = 3'h5;
   localparam logic [2:0] ST_INVALID   = 3'h7;

   // Framer figures, in bits; ALT_MIN_COMMAS counts commas
   localparam logic [3:0] CHAR_LAST      = 4'h9;
   localparam logic [3:0] LL_MAX_STRETCH = 4'h2;
   localparam logic [5:0] MB_SPAN_BITS   = 6'h32;
   localparam logic [5:0] AGE_NEXT_CHAR  = 6'h09;
   localparam logic [5:0] AGE_MAX        = 6'h3F;
   localparam logic [2:0] ALT_MIN_COMMAS = 3'h4;

   // Framing patterns, first received bit at the top
   localparam logic [7:0] COMMA_POS = 8'h3E;
   localparam logic [9:0] K285_NEG  = 10'h0FA;

   // Self-test figures
   localparam logic [8:0] LFSR_START     = 9'h000;
   localparam logic [4:0] BIST_ABORT_BAL = 5'h10;

   // Code groups
   localparam logic [5:0] K28_6B  = 6'h0F;
   localparam logic [4:0] X_K28   = 5'h1C;
   localparam logic [4:0] X_K23   = 5'h17;
   localparam logic [4:0] X_K27   = 5'h1B;
   localparam logic [4:0] X_K29   = 5'h1D;
   localparam logic [2:0] Y_7     = 3'h7;
   localparam logic [3:0] A7_NEG  = 4'h7;
   localparam logic [7:0] ALT_K23 = 8'h08;
   localparam logic [7:0] ALT_K27 = 8'h09;
   localparam logic [7:0] ALT_K29 = 8'h0A;
   localparam logic [7:0] ALT_K30 = 8'h0B;

   localparam logic [5:0] SIX_TBL [32] = '{
      6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
      6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
      6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
      6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
   localparam logic [3:0] FOUR_TBL [8] = '{
      4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

   // Balanced groups match exactly first, so complements never alias
   function automatic logic [5:0] dec6(input logic [5:0] c);
      logic [5:0] r;
      r = 6'h00;
      for (int i = 31; i >= 0; i--) begin
         if (c == ~SIX_TBL[i]) r = {1'h1, 5'(i)};
      end
      for (int i = 31; i >= 0; i--) begin
         if (c == SIX_TBL[i]) r = {1'h1, 5'(i)};
      end
      if (c == K28_6B || c == ~K28_6B) r = {1'h1, X_K28};
      return r;
   endfunction

   // Returns {valid, alternate form, y}
   function automatic logic [4:0] dec4(input logic [3:0] c);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 7; i >= 0; i--) begin
         if (c == ~FOUR_TBL[i]) r = {2'h2, 3'(i)};
      end
      for (int i = 7; i >= 0; i--) begin
         if (c == FOUR_TBL[i]) r = {2'h2, 3'(i)};
      end
      if (c == A7_NEG || c == ~A7_NEG) r = {2'h3, Y_7};
      return r;
   endfunction

   function automatic logic [8:0] lfsr_next(input logic [8:0] s);
      return {s[7:0], ~(s[8] ^ s[4])};
   endfunction

   function automatic logic legal_special(input logic [7:0] b);
      return (b[4:0] == X_K28) || (b[7:5] == Y_7 &&
             (b[4:0] == X_K23 || b[4:0] == X_K27 ||
              b[4:0] == X_K29 || b[4:0] == ~5'h01));
   endfunction

endpackage

// [tb/link_tx_model.sv]
// Serial transmitter model: ten-bit characters, first bit first
`timescale 1ns/1ns
`default_nettype none
module link_tx_model (
   input  wire logic       clk_i,
   input  wire logic [9:0] char_i,
   input  wire logic       slip_i,
   output logic            bit_o
);
   logic [9:0] shift = 10'h000;
   logic [3:0] pos   = 4'h0;
   assign bit_o = shift[9];
   // Slip repeats a bit, so the receiver has a new phase to find
   always_ff @(posedge clk_i) begin
      if (!slip_i && pos == 4'h9) begin
         shift <= char_i;
         pos   <= 4'h0;
      end else if (!slip_i) begin
         shift <= {shift[8:0], 1'b0};
         pos   <= pos + 4'h1;
      end
   end
endmodule
`default_nettype wire

// [tb/rx_framer_decoder_bist_chk.sv]
// Port-level assertions for the receive framer, decoder and self-test
`timescale 1ns/1ns
`default_nettype none
module rx_fdb_chk #(
   parameter int NUM_CH = 4
) (
   input wire logic                              clk_i,
   input wire logic                              rst_i,
   input wire logic [rx_fdb_pkg::ADDR_W-1:0]     wb_adr_i,
   input wire logic [31:0]                       wb_dat_i,
   input wire logic [31:0]                       wb_dat_o,
   input wire logic                              wb_we_i,
   input wire logic [3:0]                        wb_sel_i,
   input wire logic                              wb_cyc_i,
   input wire logic                              wb_stb_i,
   input wire logic                              wb_ack_o,
   input wire logic [NUM_CH-1:0]                 rx_bit_i,
   input wire rx_fdb_pkg::rx_char_t [NUM_CH-1:0] rx_out_o,
   input wire logic [NUM_CH-1:0]                 rx_valid_o,
   input wire logic [NUM_CH-1:0]                 rx_clk_o
);
   import rx_fdb_pkg::*;
   logic       rate;
   tri_lvl_t   dec;
   logic [4:0] quiet;
   logic       settled;
   assign settled = (quiet == 5'h1F);
   // Mode mirror; the byte and clock checks wait until a CTRL write has settled
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rate  <= 1'b0;
         dec   <= LVL_MID;
         quiet <= 5'h00;
      end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
                   wb_adr_i == CTRL_OFS && wb_sel_i[0]) begin
         rate  <= wb_dat_i[7];
         dec   <= tri_lvl_t'(wb_dat_i[6:5]);
         quiet <= 5'h00;
      end else if (!settled) begin
         quiet <= quiet + 5'h01;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack_once;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_once: assert property (p_ack_once)
      else $error("ack held too long");
   property p_ack_next;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next)
      else $error("ack late");
   property p_unmapped_zero;
      wb_ack_o && !wb_we_i && wb_adr_i != CTRL_OFS && wb_adr_i != STAT_OFS
         |-> wb_dat_o == 32'h0000_0000;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero)
      else $error("unmapped read not zero");
   property p_state_onehot;
      wb_ack_o && !wb_we_i && wb_adr_i == STAT_OFS
         |-> $onehot(wb_dat_o[5:3]) && wb_dat_o[7:6] == 2'h0;
   endproperty
   a_state_onehot: assert property (p_state_onehot)
      else $error("bad self-test state");
   property p_gap_min;
      rx_valid_o[0] |=> !rx_valid_o[0] [*8] ##1 !rx_valid_o[0];
   endproperty
   a_gap_min: assert property (p_gap_min)
      else $error("characters too close");
   property p_gap_max;
      rx_valid_o[0] |-> ##[10:12] rx_valid_o[0];
   endproperty
   a_gap_max: assert property (p_gap_max)
      else $error("character period stretched too far");
   property p_parity;
      rx_valid_o[0] |-> ^{rx_out_o[0].data, rx_out_o[0].parity};
   endproperty
   a_parity: assert property (p_parity)
      else $error("parity not odd");
   property p_byte;
      rx_valid_o[0] && settled && (dec == LVL_MID || dec == LVL_HIGH)
         |-> rx_out_o[0].data[9:8] == 2'h0;
   endproperty
   a_byte: assert property (p_byte)
      else $error("decoded upper bits set");
   property p_clk_full;
      settled && !rate |-> rx_clk_o[0] == rx_valid_o[0];
   endproperty
   a_clk_full: assert property (p_clk_full)
      else $error("character clock off strobe");
   property p_clk_half;
      settled && rate |-> (rx_clk_o[0] != $past(rx_clk_o[0])) == rx_valid_o[0];
   endproperty
   a_clk_half: assert property (p_clk_half)
      else $error("half-rate clock off strobe");
   property p_reset_quiet;
      disable iff (1'b0) rst_i |=> !wb_ack_o && rx_valid_o == '0;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("outputs active in reset");
endmodule
bind rx_framer_decoder_bist rx_fdb_chk #(.NUM_CH(NUM_CH)) rx_fdb_chk_i (
   .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .rx_bit_i(rx_bit_i), .rx_out_o(rx_out_o), .rx_valid_o(rx_valid_o),
   .rx_clk_o(rx_clk_o));
`default_nettype wire

// [tb/tb_rx_framer_decoder_bist.sv]
// Self-checking bench for the receive framer, decoder and self-test
`timescale 1ns/1ns
`default_nettype none
module tb_rx_framer_decoder_bist;
   import rx_fdb_pkg::*;
   localparam logic [9:0] D00 = 10'h274;
   localparam rx_char_t   ALN = {10'h005, ST_SPECIAL, 1'b1};
   logic        clk_i   = 1'b0;
   logic        rst_i   = 1'b1;
   logic [3:0]  adr     = 4'h0;
   logic [31:0] wdat    = 32'h0000_0000;
   logic        we      = 1'b0;
   logic        cyc     = 1'b0;
   logic        stb     = 1'b0;
   logic [3:0]  sel     = 4'h0;
   logic [9:0]  tx_char = K285_NEG;
   logic        slip    = 1'b0;
   logic [31:0] rdat;
   rx_char_t    got;
   int          errors       = 0;
   int          total_checks = 0;
   int          cycles       = 0;
   tri_lvl_t    fm_t [4] = '{LVL_LOW, LVL_LOW, LVL_MID, LVL_HIGH};
   tri_lvl_t    fc_t [4] = '{LVL_HIGH, LVL_HIGH, LVL_MID, LVL_HIGH};
   logic        rt_t [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
   int          wt_t [4] = '{11, 16, 12, 12};
   wire logic           bit_w;
   wire logic [31:0]    dat_o;
   wire logic           ack;
   wire rx_char_t [3:0] rx_out;
   wire logic [3:0]     rx_valid;
   wire logic [3:0]     rx_clk;

   always #5 clk_i = ~clk_i;

   rx_framer_decoder_bist rx_framer_decoder_bist_i (
      .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_dat_o(dat_o), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_ack_o(ack), .rx_bit_i({4{bit_w}}),
      .rx_out_o(rx_out), .rx_valid_o(rx_valid), .rx_clk_o(rx_clk));

   link_tx_model link_tx_model_i (
      .clk_i(clk_i), .char_i(tx_char), .slip_i(slip), .bit_o(bit_w));

   task automatic wrap_up;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic bus(input logic [3:0] a, input logic w,
                      input logic [31:0] d);
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      adr  <= a;
      we   <= w;
      wdat <= d;
      sel  <= 4'hF;
      do @(posedge clk_i); while (ack !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic cfg(input logic fen, input tri_lvl_t fm,
                      input tri_lvl_t fc, input tri_lvl_t dm,
                      input logic rt, input logic le, input logic [7:0] ce);
      ctrl_t c;
      c = '0;
      c.framer_enable         = fen;
      c.framer_mode_select    = fm;
      c.framing_char_select   = fc;
      c.decoder_mode_select   = dm;
      c.rx_clock_rate_select  = rt;
      c.rx_clock_select       = LVL_MID;
      c.selftest_latch_enable = le;
      c.channel_enable_bus    = ce;
      bus(CTRL_OFS, 1'b1, c);
   endtask

   // Count character strobes on channel 0, keep the last one
   task automatic chars(input int n);
      repeat (n) begin
         do @(posedge clk_i); while (rx_valid[0] !== 1'b1);
      end
      got = rx_out[0];
   endtask

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         wrap_up();
      end
   end

   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(CTRL_OFS, 1'b0, 32'h0000_0000);
      check("ctrl reset", rdat, CTRL_RST);
      bus(STAT_OFS, 1'b0, 32'h0000_0000);
      check("bist off", rdat & 32'h3838_3838, 32'h0808_0808);
      bus(4'h8, 1'b1, 32'hFFFF_FFFF);
      bus(4'h8, 1'b0, 32'h0000_0000);
      check("unmapped", rdat, 32'h0000_0000);
      cfg(1'b1, LVL_MID, LVL_HIGH, LVL_HIGH, 1'b0, 1'b0, 8'hFF);
      chars(12);
      // Each pass starts aligned, then slips one bit with framing off
      for (int i = 0; i < 4; i++) begin
         tx_char <= K285_NEG;
         cfg(1'b0, fm_t[i], fc_t[i], LVL_HIGH, rt_t[i], 1'b0, 8'hFF);
         @(posedge clk_i);
         slip <= 1'b1;
         @(posedge clk_i);
         slip <= 1'b0;
         chars(30);
         check("frozen", got == ALN, 1'b0);
         cfg(1'b1, fm_t[i], fc_t[i], LVL_HIGH, rt_t[i], 1'b0, 8'hFF);
         chars(wt_t[i]);
         check("aligned", got, ALN);
         check("aligned ch3", rx_out[3], ALN);
         tx_char <= D00;
         chars(3);
         check("data", got, {10'h000, ST_DATA, 1'b1});
      end
      cfg(1'b1, LVL_HIGH, LVL_HIGH, LVL_LOW, 1'b0, 1'b0, 8'hFF);
      chars(3);
      check("raw", {got.data, got.parity}, {D00, 1'b0});
      tx_char <= K285_NEG;
      cfg(1'b1, LVL_HIGH, LVL_HIGH, LVL_MID, 1'b0, 1'b0, 8'hFF);
      chars(3);
      check("primary", got.status, ST_SPECIAL);
      cfg(1'b1, LVL_HIGH, LVL_HIGH, LVL_MID, 1'b0, 1'b1, 8'hFE);
      chars(4);
      check("hunt", got.status, ST_BIST_WAIT);
      cfg(1'b1, LVL_HIGH, LVL_HIGH, LVL_MID, 1'b0, 1'b0, 8'hFE);
      cfg(1'b1, LVL_HIGH, LVL_HIGH, LVL_LOW, 1'b0, 1'b0, 8'hFF);
      chars(4);
      check("bypass", got.status, ST_BIST_WAIT);
      tx_char <= D00;
      cfg(1'b1, LVL_HIGH, LVL_HIGH, LVL_MID, 1'b0, 1'b0, 8'hFF);
      chars(6);
      check("mismatch", got.status, ST_MISMATCH);
      check("ch1 normal", rx_out[1].status, ST_DATA);
      bus(STAT_OFS, 1'b0, 32'h0000_0000);
      check("checking", rdat[5:3], BS_CHECK);
      tx_char <= K285_NEG;
      chars(40);
      bus(STAT_OFS, 1'b0, 32'h0000_0000);
      check("abort", rdat[5:3], BS_HUNT);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(STAT_OFS, 1'b0, 32'h0000_0000);
      check("latch reset", rdat[5:3], BS_OFF);
      wrap_up();
   end
endmodule
`default_nettype wire
